// ===== hw/flash_protect_pkg.sv
package flash_protect_pkg;

  localparam int ADDR_W = 20;
  localparam int WORD_W = 16;
  localparam int SHIFT_W = 48;
  localparam int CNT_W = 6;

  // status register layout
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int LEVEL_LSB = 2;
  localparam int LEVEL_W = 3;
  localparam int RSVD_BIT = 5;
  localparam int AAI_BIT = 6;
  localparam int LOCK_BIT = 7;

  // power-up values
  localparam logic BUSY_RESET = 1'b0;
  localparam logic WEL_RESET = 1'b0;
  localparam logic [2:0] LEVEL_RESET = 3'h7;
  localparam logic RSVD_VALUE = 1'b0;
  localparam logic AAI_RESET = 1'b0;
  localparam logic LOCK_RESET = 1'b0;

  // instruction codes
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_AUTO_INCR = 8'hAD;

  // instruction lengths in serial clock rising edges
  localparam logic [5:0] LEN_OPCODE = 6'h08;
  localparam logic [5:0] LEN_STATUS_WRITE = 6'h10;
  localparam logic [5:0] LEN_ERASE = 6'h20;
  localparam logic [5:0] LEN_PROGRAM = 6'h28;
  localparam logic [5:0] LEN_AAI_FIRST = 6'h30;
  localparam logic [5:0] LEN_AAI_NEXT = 6'h18;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // protection decode
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_ALL_FROM = 3'h5;
  localparam logic [4:0] BLOCK_COUNT = 5'h10;
  localparam logic [19:0] AAI_TOP_ADDR = 20'hFFFFE;
  localparam logic [19:0] AAI_STEP = 20'h00002;

  localparam logic [3:0] PIN_SYNC_INIT = 4'hF;

  typedef enum logic [2:0] {
    ARR_IDLE,
    ARR_BYTE,
    ARR_SECTOR,
    ARR_BLOCK,
    ARR_CHIP,
    ARR_WORD
  } array_cmd_t;

  // true when the 64K block holding addr lies in the protected region
  function automatic logic prot_hit(input logic [2:0] level,
                                    input logic [19:0] addr,
                                    input logic at_top);
    logic [4:0] blocks;
    logic [4:0] blk;
    blocks = 5'h01 << (level - 3'h1);
    blk = {1'b0, addr[19:16]};
    if (level == LEVEL_NONE) begin
      prot_hit = 1'b0;
    end else if (level >= LEVEL_ALL_FROM) begin
      prot_hit = 1'b1;
    end else if (at_top) begin
      prot_hit = blk >= (BLOCK_COUNT - blocks);
    end else begin
      prot_hit = blk < blocks;
    end
  endfunction

endpackage

// ===== hw/flash_protect_status.sv
`timescale 1ns/1ns
`default_nettype none

module flash_protect_status #(
  parameter logic PROTECT_AT_TOP = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial pins
  input wire logic ce_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // array operation port
  output logic array_req_o,
  output flash_protect_pkg::array_cmd_t array_cmd_o,
  output logic [flash_protect_pkg::ADDR_W-1:0] array_addr_o,
  output logic [flash_protect_pkg::WORD_W-1:0] array_data_o,
  input wire logic array_done_i,
  // state view
  output logic [7:0] status_o,
  output logic hold_o
);
  import flash_protect_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edges

  logic [3:0] pins_sync;
  logic si_sync;
  logic ce_n_s;
  logic sck_s;
  logic wp_n_s;
  logic hold_n_s;
  logic sck_prev_reg;
  logic ce_prev_reg;

  pin_sync #(.W(4), .INIT(PIN_SYNC_INIT)) ctl_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i({ce_n_i, sck_i, wp_n_i, hold_n_i}),
    .sync_o(pins_sync)
  );

  pin_sync #(.W(1), .INIT(1'b0)) data_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(si_i),
    .sync_o(si_sync)
  );

  assign ce_n_s = pins_sync[3];
  assign sck_s = pins_sync[2];
  assign wp_n_s = pins_sync[1];
  assign hold_n_s = pins_sync[0];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev_reg <= 1'b1;
      ce_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      ce_prev_reg <= ce_n_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pause control

  logic hold_reg;
  logic hold_enter;
  logic hold_exit;
  logic sck_rise;
  logic sck_fall;
  logic ce_rise;

  assign hold_enter = ~hold_reg & ~ce_n_s & ~hold_n_s & ~sck_s;
  assign hold_exit = hold_reg & hold_n_s & ~sck_s;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_reg <= 1'b0;
    end else if (hold_enter) begin
      hold_reg <= 1'b1;
    end else if (hold_exit) begin
      hold_reg <= 1'b0;
    end
  end

  // clock edges are invisible while paused
  assign sck_rise = sck_s & ~sck_prev_reg & ~ce_n_s & ~hold_reg;
  assign sck_fall = ~sck_s & sck_prev_reg & ~ce_n_s & ~hold_reg;
  assign ce_rise = ce_n_s & ~ce_prev_reg;

  //////////////////////////////////////////////////////////////////////////
  // serial shifter

  logic [SHIFT_W-1:0] shift_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] op_reg;
  logic [7:0] op_next;

  assign op_next = {shift_reg[6:0], si_sync};

  // chip select high clears the sequence, also inside a pause
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_reg <= 6'h00;
    end else if (ce_n_s) begin
      bit_cnt_reg <= 6'h00;
    end else if (sck_rise && bit_cnt_reg != CNT_MAX) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[SHIFT_W-2:0], si_sync};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_reg <= 8'h00;
    end else if (sck_rise && bit_cnt_reg == LEN_OPCODE - 6'h01) begin
      op_reg <= op_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status register

  logic busy_reg;
  logic wel_reg;
  logic [2:0] level_reg;
  logic aai_reg;
  logic lock_reg;
  logic [7:0] status;

  assign status = {lock_reg, aai_reg, RSVD_VALUE, level_reg,
                   wel_reg, busy_reg};

  //////////////////////////////////////////////////////////////////////////
  // instruction decode at chip select release

  logic exec;
  logic [19:0] prog_addr;
  logic [19:0] erase_addr;
  logic [19:0] aai_first_addr;
  logic [19:0] aai_addr_reg;
  logic normal_ok;
  logic do_write_enable_instr;
  logic do_write_disable_instr;
  logic do_status_write_instr;
  logic status_write_instr_allowed;
  logic do_byte;
  logic do_sector;
  logic do_block;
  logic do_chip;
  logic do_aai_first;
  logic do_aai_next;
  logic launch;
  logic [7:0] status_data;

  // busy lets nothing but status reads through
  assign exec = ce_rise & ~hold_reg & ~busy_reg;

  assign prog_addr = shift_reg[27:8];
  assign erase_addr = shift_reg[19:0];
  assign aai_first_addr = shift_reg[35:16];
  assign status_data = shift_reg[7:0];

  assign normal_ok = wel_reg & ~aai_reg;

  assign do_write_enable_instr = exec & op_reg == OP_WRITE_ENABLE &
                   bit_cnt_reg == LEN_OPCODE;
  assign do_write_disable_instr = exec & op_reg == OP_WRITE_DISABLE &
                   bit_cnt_reg == LEN_OPCODE;
  assign do_status_write_instr = exec & op_reg == OP_STATUS_WRITE &
                   bit_cnt_reg == LEN_STATUS_WRITE;
  assign status_write_instr_allowed = wp_n_s | ~lock_reg;

  assign do_byte = exec & op_reg == OP_BYTE_PROGRAM &
                   bit_cnt_reg == LEN_PROGRAM & normal_ok &
                   ~prot_hit(level_reg, prog_addr, PROTECT_AT_TOP);
  assign do_sector = exec & op_reg == OP_SECTOR_ERASE &
                     bit_cnt_reg == LEN_ERASE & normal_ok &
                     ~prot_hit(level_reg, erase_addr, PROTECT_AT_TOP);
  assign do_block = exec & op_reg == OP_BLOCK_ERASE &
                    bit_cnt_reg == LEN_ERASE & normal_ok &
                    ~prot_hit(level_reg, erase_addr, PROTECT_AT_TOP);
  assign do_chip = exec & (op_reg == OP_CHIP_ERASE_A |
                   op_reg == OP_CHIP_ERASE_B) &
                   bit_cnt_reg == LEN_OPCODE & normal_ok &
                   level_reg == LEVEL_NONE;
  assign do_aai_first = exec & op_reg == OP_AUTO_INCR &
                        bit_cnt_reg == LEN_AAI_FIRST & normal_ok &
                        ~prot_hit(level_reg, aai_first_addr,
                                  PROTECT_AT_TOP);
  assign do_aai_next = exec & op_reg == OP_AUTO_INCR &
                       bit_cnt_reg == LEN_AAI_NEXT & aai_reg & wel_reg &
                       ~prot_hit(level_reg, aai_addr_reg,
                                 PROTECT_AT_TOP);

  assign launch = do_byte | do_sector | do_block | do_chip |
                  do_aai_first | do_aai_next;

  //////////////////////////////////////////////////////////////////////////
  // array request

  logic req_reg;
  array_cmd_t cmd_reg;
  array_cmd_t cmd_next;
  logic [19:0] addr_reg;
  logic [19:0] addr_next;
  logic [15:0] data_reg;
  logic [15:0] data_next;
  logic top_word_reg;
  logic done_clear;

  assign cmd_next = do_byte ? ARR_BYTE :
                    do_sector ? ARR_SECTOR :
                    do_block ? ARR_BLOCK :
                    do_chip ? ARR_CHIP : ARR_WORD;
  assign addr_next = do_byte ? prog_addr :
                     (do_sector | do_block) ? erase_addr :
                     do_chip ? 20'h00000 :
                     do_aai_first ? aai_first_addr : aai_addr_reg;
  assign data_next = do_byte ? {8'h00, status_data} : shift_reg[15:0];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= launch;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_reg <= ARR_IDLE;
      addr_reg <= 20'h00000;
      data_reg <= 16'h0000;
      top_word_reg <= 1'b0;
    end else if (launch) begin
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      top_word_reg <= addr_next == AAI_TOP_ADDR;
    end
  end

  // word address for the next auto-increment step
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aai_addr_reg <= 20'h00000;
    end else if (do_aai_first | do_aai_next) begin
      aai_addr_reg <= addr_next + AAI_STEP;
    end
  end

  // finished operations that drop the write-enable latch
  assign done_clear = busy_reg & array_done_i &
                      (cmd_reg != ARR_WORD | top_word_reg);

  //////////////////////////////////////////////////////////////////////////
  // status bit updates

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_reg <= BUSY_RESET;
    end else begin
      busy_reg <= launch | (busy_reg & ~array_done_i);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wel_reg <= WEL_RESET;
    end else begin
      wel_reg <= do_write_enable_instr | (wel_reg & ~(do_write_disable_instr | do_status_write_instr | done_clear));
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aai_reg <= AAI_RESET;
    end else if (do_aai_first) begin
      aai_reg <= 1'b1;
    end else if (do_write_disable_instr | (done_clear & cmd_reg == ARR_WORD)) begin
      aai_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_reg <= LEVEL_RESET;
      lock_reg <= LOCK_RESET;
    end else if (do_status_write_instr && status_write_instr_allowed) begin
      level_reg <= status_data[LEVEL_LSB +: LEVEL_W];
      lock_reg <= status_data[LOCK_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status read out

  logic rdsr_phase;
  logic [2:0] out_idx_reg;
  logic so_reg;

  assign rdsr_phase = op_reg == OP_READ_STATUS & bit_cnt_reg >= LEN_OPCODE;

  // bits leave msb first on falling clock, repeating while selected
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_idx_reg <= 3'h0;
      so_reg <= 1'b0;
    end else if (ce_n_s) begin
      out_idx_reg <= 3'h0;
    end else if (sck_fall && rdsr_phase) begin
      out_idx_reg <= out_idx_reg + 3'h1;
      so_reg <= status[~out_idx_reg];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign so_o = so_reg;
  assign so_oe_o = ~ce_n_s & ~hold_reg & rdsr_phase;
  assign array_req_o = req_reg;
  assign array_cmd_o = cmd_reg;
  assign array_addr_o = addr_reg;
  assign array_data_o = data_reg;
  assign status_o = status;
  assign hold_o = hold_reg;

endmodule

`default_nettype wire

// ===== hw/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pins
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

`default_nettype wire

// ===== verification/flash_protect_status_checker.sv
`timescale 1ns/1ns
`default_nettype none
module flash_protect_status_checker #(
  parameter logic PROTECT_AT_TOP = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pins
  input wire logic ce_n_i,
  input wire logic sck_i,
  input wire logic so_oe_o,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // array port
  input wire logic array_req_o,
  input wire flash_protect_pkg::array_cmd_t array_cmd_o,
  input wire logic [19:0] array_addr_o,
  input wire logic array_done_i,
  // state
  input wire logic [7:0] status_o,
  input wire logic hold_o
);
  import flash_protect_pkg::*;
  logic [4:0] nblk;
  logic [4:0] blk;
  logic hit;
  assign blk = {1'b0, array_addr_o[19:16]};
  assign nblk = (status_o[4:2] == 3'h0) ? 5'h00 :
    (status_o[4:2] > 3'h4) ? 5'h10 : 5'h01 << (status_o[4:2] - 3'h1);
  assign hit = PROTECT_AT_TOP ? (blk >= 5'h10 - nblk) : (blk < nblk);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  property p_req_busy; array_req_o |-> status_o[0]; endproperty
  a_req_busy: assert property (p_req_busy) else $error("no busy");
  property p_busy_hold; status_o[0] && !array_done_i |=> status_o[0];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy");
  property p_done_clear;
    status_o[0] && array_done_i && array_cmd_o != ARR_WORD
      |=> !status_o[0] && !status_o[1];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("end");
  property p_req_latch;
    array_req_o |-> $past(status_o[1]) && !$past(status_o[0]);
  endproperty
  a_req_latch: assert property (p_req_latch) else $error("wel");
  property p_chip_level;
    array_req_o && array_cmd_o == ARR_CHIP |-> status_o[4:2] == 3'h0;
  endproperty
  a_chip_level: assert property (p_chip_level) else $error("chip");
  property p_prot; array_req_o && array_cmd_o != ARR_CHIP |-> !hit;
  endproperty
  a_prot: assert property (p_prot) else $error("protected");
  property p_lock;
    $changed({status_o[7], status_o[4:2]}) && !wp_n_i
      |-> !$past(status_o[7]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_word_flag;
    array_req_o && array_cmd_o == ARR_WORD |-> ##1 status_o[6];
  endproperty
  a_word_flag: assert property (p_word_flag) else $error("aai");
  property p_pause_oe; hold_o |-> !so_oe_o; endproperty
  a_pause_oe: assert property (p_pause_oe) else $error("so oe");
  property p_enter; (!ce_n_i && !hold_n_i && !sck_i) [*5] |-> hold_o;
  endproperty
  a_enter: assert property (p_enter) else $error("enter");
  property p_leave; (!ce_n_i && hold_n_i && !sck_i) [*5] |-> !hold_o;
  endproperty
  a_leave: assert property (p_leave) else $error("leave");
  c_chip: cover property (array_req_o && array_cmd_o == ARR_CHIP);
  c_word: cover property (array_req_o && array_cmd_o == ARR_WORD);
  c_pause: cover property ($rose(hold_o));
endmodule
bind flash_protect_status flash_protect_status_checker #(
  .PROTECT_AT_TOP(PROTECT_AT_TOP)) chk_i (.clk_i(clk_i),
  .reset_i(reset_i), .ce_n_i(ce_n_i), .sck_i(sck_i), .so_oe_o(so_oe_o),
  .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .array_req_o(array_req_o),
  .array_cmd_o(array_cmd_o), .array_addr_o(array_addr_o),
  .array_done_i(array_done_i), .status_o(status_o), .hold_o(hold_o));
`default_nettype wire

// ===== verification/serial_flash_protect_status_hold_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module serial_flash_protect_status_hold_tb;
  import flash_protect_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic array_done_i = 1'b0;
  wire logic ce_n, sck, si, so, so_oe, wp_n, hold_n, req, hold, so_w;
  wire logic [19:0] addr;
  wire logic [15:0] data;
  wire logic [7:0] st;
  array_cmd_t cmd;
  int err_total = 0;
  int total_checks = 0;
  int n_req = 0;
  int cyc = 0;
  int k;
  logic [47:0] q;
  logic [7:0] s;
  assign so_w = so_oe ? so : cyc[0];
  flash_protect_status flash_protect_status_i (.clk_i(clk_i),
    .reset_i(reset_i), .ce_n_i(ce_n), .sck_i(sck), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .wp_n_i(wp_n), .hold_n_i(hold_n), .array_req_o(req),
    .array_cmd_o(cmd), .array_addr_o(addr), .array_data_o(data),
    .array_done_i(array_done_i), .status_o(st), .hold_o(hold));
  spi_host_model spi_host_model_i (.clk_i(clk_i), .so_i(so_w),
    .ce_n_o(ce_n), .sck_o(sck), .si_o(si), .wp_n_o(wp_n),
    .hold_n_o(hold_n));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (req) n_req++;
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmd_tx(input logic [47:0] d, input int n);
    spi_host_model_i.xfer(d, n, q);
  endtask
  task automatic sw(input logic [7:0] v);
    cmd_tx({8'h01, v}, 16);
  endtask
  task automatic done_op;
    `CHK(st[0], 1'b1)
    @(posedge clk_i);
    #1 array_done_i = 1'b1;
    @(posedge clk_i);
    #1 array_done_i = 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(st[0], 1'b0)
  endtask
  task automatic t_reset;
    `CHK(st, 8'h1C)
    cmd_tx(48'h0500, 16);
    `CHK(q[7:0], 8'h1C)
    $display("reset test done");
  endtask
  task automatic t_status;
    sw(8'hFF);
    `CHK(st, 8'h9C)
    spi_host_model_i.wp(1'b0);
    cmd_tx(48'h06, 8);
    sw(8'h00);
    `CHK(st, 8'h9C)
    spi_host_model_i.wp(1'b1);
    sw(8'h00);
    `CHK(st, 8'h00)
    $display("status write test done");
  endtask
  task automatic t_wel;
    k = n_req;
    cmd_tx({8'h02, 24'h012345, 8'hA5}, 40);
    `CHK(n_req, k)
    cmd_tx(48'h06, 8);
    cmd_tx({8'h02, 24'h012345, 8'hA5}, 40);
    `CHK(n_req, k + 1)
    `CHK(cmd, ARR_BYTE)
    `CHK({addr, data[7:0]}, 28'h12345A5)
    cmd_tx(48'h04, 8);
    `CHK(st, 8'h03)
    done_op();
    `CHK(st, 8'h00)
    cmd_tx(48'h06, 8);
    cmd_tx(48'h04, 8);
    `CHK(st, 8'h00)
    $display("latch test done");
  endtask
  task automatic t_levels;
    int n;
    for (int l = 0; l < 8; l++) begin
      n = (l == 0) ? 0 : (l > 4) ? 16 : 1 << (l - 1);
      sw(8'(l << 2));
      cmd_tx(48'h06, 8);
      if (n > 0) begin
        k = n_req;
        cmd_tx({8'h20, 4'h0, 4'(16 - n), 16'h0000}, 32);
        `CHK(n_req, k)
        `CHK(st[1], 1'b1)
      end
      if (n < 16) begin
        k = n_req;
        cmd_tx({8'hD8, 4'h0, 4'(15 - n), 16'hFFFF}, 32);
        `CHK(n_req, k + 1)
        `CHK(cmd, ARR_BLOCK)
        `CHK(addr, {4'(15 - n), 16'hFFFF})
        done_op();
      end
    end
    $display("level test done");
  endtask
  task automatic t_chip;
    sw(8'h04);
    cmd_tx(48'h06, 8);
    k = n_req;
    cmd_tx(48'h60, 8);
    `CHK(n_req, k)
    sw(8'h00);
    cmd_tx(48'h06, 8);
    cmd_tx(48'hC7, 8);
    `CHK(n_req, k + 1)
    `CHK(cmd, ARR_CHIP)
    done_op();
    `CHK(st, 8'h00)
    $display("chip erase test done");
  endtask
  task automatic t_aai;
    cmd_tx(48'h06, 8);
    cmd_tx({8'hAD, 24'h0FFFFC, 16'h1234}, 48);
    `CHK({cmd, addr, data}, {ARR_WORD, 20'hFFFFC, 16'h1234})
    `CHK(st, 8'h43)
    done_op();
    `CHK(st, 8'h42)
    cmd_tx({8'hAD, 16'h5678}, 24);
    `CHK({addr, data}, 36'hFFFFE5678)
    done_op();
    `CHK(st, 8'h00)
    $display("auto increment test done");
  endtask
  task automatic t_hold;
    spi_host_model_i.sel(1'b0);
    spi_host_model_i.shift(48'h010, 12, q);
    spi_host_model_i.pause(1'b0);
    `CHK({hold, so_oe}, 2'b10)
    spi_host_model_i.pause(1'b1);
    `CHK(hold, 1'b0)
    spi_host_model_i.shift(48'hC, 4, q);
    spi_host_model_i.sel(1'b1);
    `CHK(st, 8'h0C)
    spi_host_model_i.sel(1'b0);
    spi_host_model_i.shift(48'h010, 12, q);
    spi_host_model_i.pause(1'b0);
    spi_host_model_i.sel(1'b1);
    spi_host_model_i.pause(1'b1);
    `CHK(st, 8'h0C)
    $display("pause test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    t_reset();
    t_status();
    t_wel();
    t_levels();
    t_chip();
    t_aai();
    t_hold();
    reset_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire

// ===== verification/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  input wire logic so_i,
  output logic ce_n_o,
  output logic sck_o,
  output logic si_o,
  output logic wp_n_o,
  output logic hold_n_o
);
  initial begin
    ce_n_o = 1'b1;
    sck_o = 1'b1;
    si_o = 1'b0;
    wp_n_o = 1'b1;
    hold_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // sck idles high; released si flips
  task automatic sel(input logic v);
    ce_n_o = v;
    sck_o = 1'b1;
    if (v) si_o = ~si_o;
    tick(8);
  endtask
  // msb first, so sampled at rising sck
  task automatic shift(input logic [47:0] d, input int n,
                       output logic [47:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = d[i];
      tick(8);
      sck_o = 1'b1;
      q = {q[46:0], so_i};
      tick(8);
    end
  endtask
  task automatic xfer(input logic [47:0] d, input int n,
                      output logic [47:0] q);
    sel(1'b0);
    shift(d, n, q);
    sel(1'b1);
  endtask
  // sck low only while selected
  task automatic pause(input logic h);
    sck_o = ce_n_o;
    hold_n_o = h;
    tick(8);
  endtask
  task automatic wp(input logic v);
    wp_n_o = v;
    tick(8);
  endtask
endmodule
`default_nettype wire
